// ==== hw/wdx_dbuf.sv ====
/*
  Double-buffered setting: a write lands in a buffer, the buffer is copied
  to the active value at the next update point.
  Assumes write and update strobes are one-cycle pulses on clk_sys_i.
*/
`timescale 1ns/1ps
module wdx_dbuf #(
  parameter int unsigned W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic         update_i,
  output logic      [W-1:0] active_o,
  output logic              pending_o
);
  import wdx_pkg::*;

  typedef struct packed {
    logic [W-1:0] buffered;
    logic [W-1:0] active;
    logic         pending;
  } wdx_dbuf_state_t;

  wdx_dbuf_state_t s;
  wdx_dbuf_state_t next_s;

  // ----------------------------------------------------------------------
  // Buffer and apply
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (update_i && s.pending) begin
      next_s.active  = s.buffered;
      next_s.pending = 1'b0;
    end
    // A write in the update cycle waits for the next update, set wins
    if (wr_i) begin
      next_s.buffered = data_i;
      next_s.pending  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '{buffered: RST, active: RST, pending: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign active_o  = s.active;
  assign pending_o = s.pending;

endmodule

// ==== hw/wdx_dead_time_unit.sv ====
/*
  One dead-time unit: splits a waveform into a low side that follows it and
  a high side that follows its inverse, with both held low for the active
  dead time before either side turns on.
  Assumes dead-time values are already the double-buffered active ones.
*/
`timescale 1ns/1ps
module wdx_dead_time_unit (
  input  wire logic                         clk_sys_i,
  input  wire logic                         resetn_i,
  input  wire logic                         enable_i,
  input  wire logic                         wave_i,
  input  wire logic [wdx_pkg::WDX_DT_W-1:0] dt_ls_i,
  input  wire logic [wdx_pkg::WDX_DT_W-1:0] dt_hs_i,
  output logic                              low_side_o,
  output logic                              high_side_o,
  output logic                              dead_o
);
  import wdx_pkg::*;

  typedef enum logic [2:0] {
    DTU_OFF,
    DTU_LS_ON,
    DTU_HS_ON,
    DTU_TO_LS,
    DTU_TO_HS
  } wdx_dtu_st_t;

  typedef struct packed {
    wdx_dtu_st_t         st;
    logic [WDX_DT_W-1:0] cnt;
    logic                ls;
    logic                hs;
    logic                dead;
  } wdx_dtu_state_t;

  wdx_dtu_state_t s;
  wdx_dtu_state_t next_s;

  // Head for side t: straight on with zero dead time, else dead first
  function automatic wdx_dtu_state_t start(input logic t, input logic [WDX_DT_W-1:0] dt);
    wdx_dtu_state_t r;
    r.cnt = dt;
    if (dt == '0) begin
      r.st   = t ? DTU_LS_ON : DTU_HS_ON;
      r.ls   = t;
      r.hs   = !t;
      r.dead = 1'b0;
    end else begin
      r.st   = t ? DTU_TO_LS : DTU_TO_HS;
      r.ls   = 1'b0;
      r.hs   = 1'b0;
      r.dead = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Switching sequence
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    case (s.st)
      DTU_OFF:   next_s = start(wave_i, wave_i ? dt_ls_i : dt_hs_i);
      DTU_LS_ON: if (!wave_i) next_s = start(1'b0, dt_hs_i);
      DTU_HS_ON: if (wave_i) next_s = start(1'b1, dt_ls_i);
      DTU_TO_LS: begin
        // A reversal mid-dead restarts toward the other side
        if (!wave_i) next_s = start(1'b0, dt_hs_i);
        else if (s.cnt == 8'h01) next_s = start(1'b1, '0);
        else next_s.cnt = s.cnt - 8'h01;
      end
      DTU_TO_HS: begin
        if (wave_i) next_s = start(1'b1, dt_ls_i);
        else if (s.cnt == 8'h01) next_s = start(1'b0, '0);
        else next_s.cnt = s.cnt - 8'h01;
      end
      default:   next_s.st = DTU_OFF;
    endcase
    // Bypassed unit still gives a complementary pair, with no gap
    if (!enable_i) begin
      next_s.st   = DTU_OFF;
      next_s.cnt  = '0;
      next_s.ls   = wave_i;
      next_s.hs   = !wave_i;
      next_s.dead = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '{st: DTU_OFF, cnt: '0, ls: 1'b0, hs: 1'b0, dead: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign low_side_o  = s.ls;
  assign high_side_o = s.hs;
  assign dead_o      = s.dead;

endmodule

// ==== hw/wdx_pkg.sv ====
/*
  Shared constants for the waveform dead-time extension: channel and pin
  counts, reset values, pin pairing and the fault clearing modes.
  Assumes a single 10 MHz clock domain shared with the timer it extends.
*/
package wdx_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned WDX_NUM_CH = 4;
  localparam int unsigned WDX_DT_W   = 8;
  localparam int unsigned WDX_PORT_W = 8;
  localparam int unsigned WDX_EVT_W  = 8;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] WDX_DT_RST  = 8'h00;
  localparam logic [7:0] WDX_PAT_RST = 8'h00;
  localparam logic [7:0] WDX_PIN_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Pin pairing: channel k drives pin 2k (low side) and 2k+1 (high side)
  // ----------------------------------------------------------------------
  localparam int unsigned WDX_LS_POS  = 0;
  localparam int unsigned WDX_HS_POS  = 1;
  localparam int unsigned WDX_PAIR    = 2;
  localparam int unsigned WDX_CHA_IDX = 0;

  typedef enum logic {
    WDX_FLT_LATCHED,
    WDX_FLT_CYCLE
  } wdx_fault_mode_t;

  function automatic int unsigned wdx_pin(input int unsigned ch, input logic hs);
    return ch * WDX_PAIR + (hs ? WDX_HS_POS : WDX_LS_POS);
  endfunction

endpackage

// ==== hw/wdx_waveform_extension.sv ====
/*
  Waveform extension behind the timer's waveform generator: complementary
  pairs with dead time, a pattern generator, channel A spreading and
  event-driven fault shutdown, all producing the port pin values.
  Assumes waveform, update, port and event inputs come from logic on
  clk_sys_i, so none of them is synchronised here.
*/
// What this block does
// - With neither pattern nor spread on, any enabled unit turns each timer waveform into a complementary pair.
// - Each enabled unit gives low side equal to waveform, high side inverted, with gap; a bypassed unit gives the pair with no gap.
// - Unit outputs replace port values only on pins selected for override.
// - Four dead-time units exist, one per compare channel.
// - High and low dead times are set separately, eight bits each.
// - Dead-time settings are buffered and applied at the update point.
// - Optionally the timer is halted while a dead interval runs.
// - The pattern generator changes all override-selected port pins in the same cycle.
// - A new pattern is buffered and takes effect at the update point.
// - On request channel A waveform drives every port pin.
// - With the pattern generator on, dead-time units are bypassed.
// - A selected event raises a fault that disables outputs at once.
`timescale 1ns/1ps
module wdx_waveform_extension #(
  parameter int unsigned EVT_W = wdx_pkg::WDX_EVT_W
) (
  input  wire logic                           clk_sys_i,
  input  wire logic                           resetn_i,
  input  wire logic [wdx_pkg::WDX_NUM_CH-1:0] wave_i,
  input  wire logic                           timer_update_i,
  input  wire logic [wdx_pkg::WDX_PORT_W-1:0] port_value_i,
  input  wire logic [wdx_pkg::WDX_PORT_W-1:0] port_override_i,
  input  wire logic [wdx_pkg::WDX_NUM_CH-1:0] dti_enable_i,
  input  wire logic                           pattern_enable_i,
  input  wire logic                           cha_spread_i,
  input  wire logic                           halt_on_dead_i,
  input  wire logic                           dt_ls_wr_i,
  input  wire logic [wdx_pkg::WDX_DT_W-1:0]   dt_ls_data_i,
  input  wire logic                           dt_hs_wr_i,
  input  wire logic [wdx_pkg::WDX_DT_W-1:0]   dt_hs_data_i,
  input  wire logic                           pattern_wr_i,
  input  wire logic [wdx_pkg::WDX_PORT_W-1:0] pattern_data_i,
  input  wire logic [EVT_W-1:0]               fault_event_i,
  input  wire logic [EVT_W-1:0]               fault_select_i,
  input  wire wdx_pkg::wdx_fault_mode_t       fault_mode_i,
  input  wire logic                           fault_clear_i,
  output logic      [wdx_pkg::WDX_PORT_W-1:0] port_o,
  output logic                              timer_halt_o,
  output logic                              fault_o,
  output logic      [wdx_pkg::WDX_NUM_CH-1:0] dead_busy_o,
  output logic                              ext_active_o,
  output logic      [wdx_pkg::WDX_DT_W-1:0]   dt_ls_active_o,
  output logic      [wdx_pkg::WDX_DT_W-1:0]   dt_hs_active_o,
  output logic      [wdx_pkg::WDX_PORT_W-1:0] pattern_active_o,
  output logic                              update_pending_o
);
  import wdx_pkg::*;

  typedef struct packed {
    logic [WDX_PORT_W-1:0] pins;
    logic                  fault;
    logic                  ext_on;
  } wdx_top_state_t;

  wdx_top_state_t s;
  wdx_top_state_t next_s;

  logic [WDX_DT_W-1:0]   dt_ls_act;
  logic [WDX_DT_W-1:0]   dt_hs_act;
  logic [WDX_PORT_W-1:0] pat_act;
  logic                  dt_ls_pend;
  logic                  dt_hs_pend;
  logic                  pat_pend;
  logic [WDX_NUM_CH-1:0] unit_en;
  logic [WDX_NUM_CH-1:0] ls_out;
  logic [WDX_NUM_CH-1:0] hs_out;
  logic [WDX_NUM_CH-1:0] dead;
  logic [WDX_PORT_W-1:0] pair_pins;
  logic [WDX_PORT_W-1:0] ext_pins;
  logic [WDX_PORT_W-1:0] ext_mask;
  logic                  any_feature;
  logic                  fault_hit;
  logic                  fault_now;
  logic                  fault_release;

  // ----------------------------------------------------------------------
  // Double-buffered settings
  // ----------------------------------------------------------------------
  wdx_dbuf #(
    .W   (WDX_DT_W),
    .RST (WDX_DT_RST)
  ) u_dt_ls_buf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_i      (dt_ls_wr_i),
    .data_i    (dt_ls_data_i),
    .update_i  (timer_update_i),
    .active_o  (dt_ls_act),
    .pending_o (dt_ls_pend)
  );

  wdx_dbuf #(
    .W   (WDX_DT_W),
    .RST (WDX_DT_RST)
  ) u_dt_hs_buf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_i      (dt_hs_wr_i),
    .data_i    (dt_hs_data_i),
    .update_i  (timer_update_i),
    .active_o  (dt_hs_act),
    .pending_o (dt_hs_pend)
  );

  wdx_dbuf #(
    .W   (WDX_PORT_W),
    .RST (WDX_PAT_RST)
  ) u_pattern_buf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_i      (pattern_wr_i),
    .data_i    (pattern_data_i),
    .update_i  (timer_update_i),
    .active_o  (pat_act),
    .pending_o (pat_pend)
  );

  // ----------------------------------------------------------------------
  // Dead-time units
  // ----------------------------------------------------------------------
  // The pattern generator takes the port, so the units fall back to bypass
  assign unit_en = dti_enable_i & {WDX_NUM_CH{!pattern_enable_i}};

  for (genvar k = 0; k < WDX_NUM_CH; k++) begin : g_unit
    wdx_dead_time_unit u_unit (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .enable_i    (unit_en[k]),
      .wave_i      (wave_i[k]),
      .dt_ls_i     (dt_ls_act),
      .dt_hs_i     (dt_hs_act),
      .low_side_o  (ls_out[k]),
      .high_side_o (hs_out[k]),
      .dead_o      (dead[k])
    );
  end

  // ----------------------------------------------------------------------
  // Pin selection and fault
  // ----------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    pair_pins     = '0;
    ext_pins      = '0;
    ext_mask      = '0;
    any_feature   = (|dti_enable_i) | pattern_enable_i | cha_spread_i;
    fault_hit     = |(fault_event_i & fault_select_i);
    fault_release = 1'b0;

    for (int unsigned k = 0; k < WDX_NUM_CH; k++) begin
      pair_pins[wdx_pin(k, 1'b0)] = ls_out[k];
      pair_pins[wdx_pin(k, 1'b1)] = hs_out[k];
    end

    // Priority: pattern, then channel A spread, then the pairs
    if (pattern_enable_i) begin
      ext_pins = pat_act;
      ext_mask = port_override_i;
    end else if (cha_spread_i) begin
      ext_pins = {WDX_PORT_W{wave_i[WDX_CHA_IDX]}};
      ext_mask = '1;
    end else begin
      ext_pins = pair_pins;
      ext_mask = port_override_i;
    end
    if (!any_feature) begin
      ext_mask = '0;
    end

    // Hardware set wins over the clear in the same cycle
    case (fault_mode_i)
      WDX_FLT_LATCHED: fault_release = fault_clear_i;
      WDX_FLT_CYCLE:   fault_release = timer_update_i;
      default:         fault_release = fault_clear_i;
    endcase
    next_s.fault = fault_hit | (s.fault & !fault_release);
    fault_now    = fault_hit | s.fault;

    // Fault forces every extension-owned pin low, the drivers go off
    if (fault_now) begin
      ext_pins = '0;
    end

    // Whole vector registered at once, so all pins move on one edge
    next_s.pins   = (ext_mask & ext_pins) | (~ext_mask & port_value_i);
    next_s.ext_on = any_feature;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '{pins: WDX_PIN_RST, fault: 1'b0, ext_on: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Halting freezes the count, so a short period cannot swallow the gap
  assign timer_halt_o     = halt_on_dead_i & (|dead);
  assign port_o           = s.pins;
  assign fault_o          = s.fault;
  assign dead_busy_o      = dead;
  assign ext_active_o     = s.ext_on;
  assign dt_ls_active_o   = dt_ls_act;
  assign dt_hs_active_o   = dt_hs_act;
  assign pattern_active_o = pat_act;
  assign update_pending_o = dt_ls_pend | dt_hs_pend | pat_pend;

endmodule

// ==== verification/waveform_dead_time_extension_tb.sv ====
/*
  Self-checking bench for the waveform extension with a gate driver model.
  Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps
module waveform_dead_time_extension_tb;
  import wdx_pkg::*;
  logic            clk_sys_i, resetn_i, timer_update_i, pattern_enable_i, cha_spread_i;
  logic            halt_on_dead_i, dt_ls_wr_i, dt_hs_wr_i, pattern_wr_i, fault_clear_i;
  logic            timer_halt_o, fault_o, ext_active_o, update_pending_o;
  logic [3:0]      wave_i, dti_enable_i, dead_busy_o;
  logic [7:0]      port_value_i, port_override_i, dt_ls_data_i, dt_hs_data_i, pattern_data_i;
  logic [7:0]      fault_event_i, fault_select_i, port_o;
  logic [7:0]      dt_ls_active_o, dt_hs_active_o, pattern_active_o;
  wdx_fault_mode_t fault_mode_i;
  int              n_errors, comparisons, cycles, shoot, len;
  wdx_waveform_extension dut_u (.*);
  wdx_gate_drv drv_u (.clk_sys_i(clk_sys_i), .pin_i(port_o), .shoot_o(shoot),
    .pairs_i((|dti_enable_i) && !pattern_enable_i && !cha_spread_i && (&port_override_i)));
  initial begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Bounded run in case a wait never ends
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("unexpected timeout");
      stop_test;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic upd;
    timer_update_i = 1;
    tick(1);
    timer_update_i = 0;
  endtask
  task automatic wr_set(input logic [7:0] ls, input logic [7:0] hs, input logic [7:0] pat);
    {dt_ls_wr_i, dt_hs_wr_i, pattern_wr_i} = 3'b111;
    {dt_ls_data_i, dt_hs_data_i, pattern_data_i} = {ls, hs, pat};
    tick(1);
    {dt_ls_wr_i, dt_hs_wr_i, pattern_wr_i} = 3'b000;
  endtask
  // Flip the waveform, check halt, then count dead cycles of channel 0
  task automatic dead_len(input logic [3:0] w, input logic halt);
    wave_i = w;
    len = 0;
    tick(1);
    chk("halt", {7'h0, halt}, {7'h0, timer_halt_o});
    while (dead_busy_o[0] === 1'b1 && len < 300) begin
      len++;
      tick(1);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {timer_update_i, pattern_enable_i, cha_spread_i, halt_on_dead_i, fault_clear_i} = '0;
    {dt_ls_wr_i, dt_hs_wr_i, pattern_wr_i, wave_i, dti_enable_i} = '0;
    {dt_ls_data_i, dt_hs_data_i, pattern_data_i, fault_event_i, fault_select_i} = '0;
    port_value_i = 8'h3c;
    port_override_i = 8'hff;
    fault_mode_i = WDX_FLT_LATCHED;
    resetn_i = 0;
    tick(10);
    resetn_i = 1;
    tick(2);
    chk("plain port", 8'h3c, port_o);
    wr_set(8'h03, 8'h02, 8'ha5);
    tick(2);
    chk("ls early", 8'h00, dt_ls_active_o);
    chk("pattern early", 8'h00, pattern_active_o);
    chk("pending", 8'h01, {7'h0, update_pending_o});
    upd;
    chk("ls active", 8'h03, dt_ls_active_o);
    chk("hs active", 8'h02, dt_hs_active_o);
    chk("pattern active", 8'ha5, pattern_active_o);
    $display("test buffers done");
    dti_enable_i = 4'hf;
    halt_on_dead_i = 1;
    tick(6);
    chk("pairs low", 8'haa, port_o);
    chk("ext", 8'h01, {7'h0, ext_active_o});
    dead_len(4'hf, 1);
    chk("ls dead", 8'h03, len[7:0]);
    tick(2);
    chk("pairs high", 8'h55, port_o);
    dead_len(4'h0, 1);
    chk("hs dead", 8'h02, len[7:0]);
    port_override_i = 8'h0f;
    port_value_i = 8'hf0;
    tick(3);
    chk("part override", 8'hfa, port_o);
    halt_on_dead_i = 0;
    dead_len(4'hf, 0);
    chk("ls dead no halt", 8'h03, len[7:0]);
    $display("test dead time done");
    port_override_i = 8'hff;
    pattern_enable_i = 1;
    tick(3);
    chk("pattern", 8'ha5, port_o);
    chk("bypass", 8'h00, {4'h0, dead_busy_o});
    wr_set(8'h03, 8'h02, 8'h3c);
    chk("pattern held", 8'ha5, port_o);
    upd;
    tick(1);
    chk("pattern new", 8'h3c, port_o);
    pattern_enable_i = 0;
    cha_spread_i = 1;
    tick(3);
    chk("spread one", 8'hff, port_o);
    wave_i = 4'he;
    tick(2);
    chk("spread zero", 8'h00, port_o);
    $display("test pattern done");
    cha_spread_i = 0;
    fault_select_i = 8'h04;
    fault_event_i = 8'hfb;
    tick(4);
    chk("no fault", 8'h00, {7'h0, fault_o});
    fault_event_i = 8'h04;
    tick(1);
    fault_event_i = 8'h00;
    chk("fault", 8'h01, {7'h0, fault_o});
    chk("fault pins", 8'h00, port_o);
    tick(3);
    chk("fault held", 8'h01, {7'h0, fault_o});
    fault_clear_i = 1;
    tick(1);
    fault_clear_i = 0;
    chk("fault clear", 8'h00, {7'h0, fault_o});
    fault_mode_i = WDX_FLT_CYCLE;
    fault_event_i = 8'h04;
    tick(1);
    fault_event_i = 8'h00;
    chk("cycle fault", 8'h01, {7'h0, fault_o});
    upd;
    chk("cycle clear", 8'h00, {7'h0, fault_o});
    chk("shoot", 8'h00, shoot[7:0]);
    $display("test fault done");
    stop_test;
  end
endmodule

// ==== verification/wdx_ext_sva.sv ====
/*
  Port checker for the waveform extension top module.
  Assumes one clock domain and the pin map 2k low side, 2k+1 high side.
*/
`timescale 1ns/1ps
module wdx_ext_sva
#(
  parameter int unsigned EVT_W = 8
) (
  input wire logic                     clk_sys_i,
  input wire logic                     resetn_i,
  input wire logic [3:0]               wave_i,
  input wire logic                     timer_update_i,
  input wire logic [7:0]               port_value_i,
  input wire logic [7:0]               port_override_i,
  input wire logic [3:0]               dti_enable_i,
  input wire logic                     pattern_enable_i,
  input wire logic                     cha_spread_i,
  input wire logic                     halt_on_dead_i,
  input wire logic                     dt_ls_wr_i,
  input wire logic                     dt_hs_wr_i,
  input wire logic                     pattern_wr_i,
  input wire logic [7:0]               pattern_data_i,
  input wire logic [EVT_W-1:0]         fault_event_i,
  input wire logic [EVT_W-1:0]         fault_select_i,
  input wire wdx_pkg::wdx_fault_mode_t fault_mode_i,
  input wire logic                     fault_clear_i,
  input wire logic [7:0]               port_o,
  input wire logic                     timer_halt_o,
  input wire logic                     fault_o,
  input wire logic [3:0]               dead_busy_o,
  input wire logic                     ext_active_o,
  input wire logic [7:0]               dt_ls_active_o,
  input wire logic [7:0]               dt_hs_active_o,
  input wire logic [7:0]               pattern_active_o,
  input wire logic                     update_pending_o
);
  import wdx_pkg::*;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic feat;
  logic hit;
  logic wr;
  assign feat = (|dti_enable_i) || pattern_enable_i || cha_spread_i;
  assign hit  = |(fault_event_i & fault_select_i);
  assign wr   = dt_ls_wr_i || dt_hs_wr_i || pattern_wr_i;
  // Write, then an update with no fresh write in the same cycle
  sequence s_pat_wr;
    pattern_wr_i ##1 (timer_update_i && !pattern_wr_i);
  endsequence
  a_halt_dead: assert property (timer_halt_o == (halt_on_dead_i && |dead_busy_o))
    else $error("halt output does not track dead flags");
  a_ext_on: assert property (feat |=> ext_active_o)
    else $error("extension not active");
  a_plain_pins: assert property (!feat && $past(!feat) && !fault_o && !hit
    |=> port_o == $past(port_value_i)) else $error("plain port value lost");
  a_buf_hold: assert property (!timer_update_i
    |=> $stable({dt_ls_active_o, dt_hs_active_o, pattern_active_o}))
    else $error("active setting changed without update");
  a_pat_load: assert property (s_pat_wr |=> pattern_active_o == $past(pattern_data_i, 2))
    else $error("pattern not applied at update");
  a_pend_clear: assert property (timer_update_i && !wr |=> !update_pending_o)
    else $error("pending left after update");
  a_spread_pins: assert property (cha_spread_i && $past(cha_spread_i) && !pattern_enable_i
    && !fault_o && !hit |=> port_o == {8{$past(wave_i[0])}})
    else $error("channel A not on all pins");
  a_fault_cut: assert property (feat && ext_active_o && hit
    |=> fault_o && (port_o & $past(port_override_i)) == 8'h00)
    else $error("fault did not cut outputs");
  a_fault_stay: assert property (fault_o && fault_mode_i == WDX_FLT_LATCHED && !fault_clear_i
    |=> fault_o) else $error("latched fault dropped");
  a_cycle_clr: assert property (fault_o && fault_mode_i == WDX_FLT_CYCLE && timer_update_i
    && !hit |=> !fault_o) else $error("cycle fault not cleared");
  a_dead_bypass: assert property ($past(pattern_enable_i) |-> dead_busy_o == 4'h0)
    else $error("dead time while pattern on");
  a_dead_low: assert property ($past(dead_busy_o[0] && port_override_i[1:0] == 2'b11
    && !pattern_enable_i && !cha_spread_i) |-> port_o[1:0] == 2'b00)
    else $error("pair not low in dead time");
endmodule
bind wdx_waveform_extension wdx_ext_sva #(.EVT_W(EVT_W)) sva_u (.*);

// ==== verification/wdx_gate_drv.sv ====
/*
  Gate driver pairs on the port pins: counts cycles with both sides on.
  Assumes pairs_i is high while the next registered pin value holds pairs.
*/
`timescale 1ns/1ps
module wdx_gate_drv (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] pin_i,
  input  wire logic       pairs_i,
  output int              shoot_o
);
  import wdx_pkg::*;
  logic pairs_q;
  // Both switches on would short the supply
  // Pins are registered, so the qualifier is delayed one cycle to match them
  initial begin
    shoot_o = 0;
    pairs_q = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      for (int k = 0; k < WDX_NUM_CH; k++) begin
        if (pairs_q && pin_i[2*k] && pin_i[2*k+1]) begin
          shoot_o++;
        end
      end
      pairs_q = pairs_i;
    end
  end
endmodule
